// ### cgt_pkg.sv
// Constants, state type and character helpers for the channel gate block.
// Assumes ASCII characters arrive one byte at a time from a UART on pclk.
package cgt_pkg;

  // ----------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_LBRACE = 8'h7B;
  localparam logic [7:0] CH_RBRACE = 8'h7D;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_HASH   = 8'h23;
  localparam logic [7:0] CH_STAR   = 8'h2A;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_O      = 8'h4F;
  localparam logic [7:0] CH_C      = 8'h43;
  localparam logic [7:0] CH_W      = 8'h57;
  localparam logic [7:0] CH_E      = 8'h45;
  localparam logic [7:0] CH_S      = 8'h53;
  localparam logic [7:0] CH_U      = 8'h55;
  localparam logic [7:0] CH_R      = 8'h52;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_ADDR   = 8'h04;
  localparam logic [7:0]  REG_SETUP  = 8'h08;
  localparam logic [7:0]  REG_STATUS = 8'h0C;
  localparam logic [1:0]  CTRL_RST   = 2'h1;
  localparam logic [23:0] ADDR_RST   = 24'h31_3031;
  localparam logic [31:0] SETUP_RST  = 32'h3107_0000;
  localparam int          CTRL_EXT   = 0;
  localparam int          CTRL_FMT7  = 1;
  localparam int          SU_FILTER  = 4;
  localparam int          SU_TRANSP  = 5;
  localparam logic [3:0]  SU_DIGITS  = 4'h8;

  // ----------------------------------------------------------------
  // Responder character slots
  // ----------------------------------------------------------------
  localparam logic [3:0] RI_ADR0 = 4'h1;
  localparam logic [3:0] RI_ADR1 = 4'h2;
  localparam logic [3:0] RI_DAT0 = 4'h5;
  localparam logic [3:0] RI_DAT7 = 4'hC;
  localparam logic [3:0] RI_CKHI = 4'hD;
  localparam logic [3:0] RI_CKLO = 4'hE;
  localparam logic [3:0] RI_LAST = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADR1, ST_ADR2, ST_CMD1, ST_CMD2, ST_TAIL, ST_SKIP
  } cgt_state_e;

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  function automatic logic [3:0] hex2nib(input logic [7:0] c);
    return (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction

  function automatic logic [7:0] nib2hex(input logic [3:0] n);
    return (n < 4'hA) ? {4'h3, n} : {4'h4, 4'(n - 4'h9)};
  endfunction

endpackage

// ### cgt_resp_tx.sv
// Response sender: builds one reply line and streams it byte by byte.
// Assumes the consumer takes a byte on tx_valid and tx_ready both high.
`timescale 1ns/10ps
module cgt_resp_tx (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request
  input  wire logic        start,
  input  wire logic        long_form,
  input  wire logic        two_addr,
  input  wire logic [7:0]  a0,
  input  wire logic [7:0]  a1,
  input  wire logic [7:0]  c0,
  input  wire logic [7:0]  c1,
  input  wire logic        has_data,
  input  wire logic [31:0] data,
  output      logic        busy,
  // Byte stream
  input  wire logic        tx_ready,
  output      logic        tx_valid,
  output      logic [7:0]  tx_data
);

  logic        busy_ff, long_ff, two_ff, hasd_ff, tx_valid_ff;
  logic [3:0]  idx_ff;
  logic [7:0]  a0_ff, a1_ff, c0_ff, c1_ff, sum_ff, tx_data_ff, cur;
  logic [31:0] data_ff, dshift;
  logic        present, step;

  // Short form keeps only prompt, data and CR
  always_comb begin
    dshift  = data_ff >> {3'(4'hC - idx_ff), 2'b00};
    present = 1'b1;
    cur     = cgt_pkg::CH_CR;
    if (idx_ff == 4'h0) begin
      cur = cgt_pkg::CH_STAR;
    end else if (idx_ff == cgt_pkg::RI_ADR0) begin
      cur     = a0_ff;
      present = long_ff;
    end else if (idx_ff == cgt_pkg::RI_ADR1) begin
      cur     = a1_ff;
      present = long_ff && two_ff;
    end else if (idx_ff < cgt_pkg::RI_DAT0) begin
      cur     = idx_ff[0] ? c0_ff : c1_ff;
      present = long_ff;
    end else if (idx_ff <= cgt_pkg::RI_DAT7) begin
      cur     = cgt_pkg::nib2hex(dshift[3:0]);
      present = hasd_ff;
    end else if (idx_ff == cgt_pkg::RI_CKHI) begin
      cur     = cgt_pkg::nib2hex(sum_ff[7:4]);
      present = long_ff;
    end else if (idx_ff == cgt_pkg::RI_CKLO) begin
      cur     = cgt_pkg::nib2hex(sum_ff[3:0]);
      present = long_ff;
    end
    step = busy_ff && (!tx_valid_ff || tx_ready);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      idx_ff  <= 4'h0;
      sum_ff  <= 8'h00;
    end else if (start && !busy_ff) begin
      busy_ff <= 1'b1;
      idx_ff  <= 4'h0;
      sum_ff  <= 8'h00;
    end else if (step) begin
      idx_ff <= 4'(idx_ff + 4'h1);
      if (idx_ff == cgt_pkg::RI_LAST) begin
        busy_ff <= 1'b0;
      end
      if (present && idx_ff < cgt_pkg::RI_CKHI) begin
        sum_ff <= 8'(sum_ff + cur);
      end
    end
  end

  // Fields held for the whole line so the parser may move on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {long_ff, two_ff, hasd_ff} <= 3'h0;
      {a0_ff, a1_ff, c0_ff, c1_ff} <= 32'h0000_0000;
      data_ff <= 32'h0000_0000;
    end else if (start && !busy_ff) begin
      {long_ff, two_ff, hasd_ff} <= {long_form, two_addr, has_data};
      {a0_ff, a1_ff, c0_ff, c1_ff} <= {a0, a1, c0, c1};
      data_ff <= data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_ff <= 1'b0;
      tx_data_ff  <= 8'h00;
    end else if (step) begin
      tx_valid_ff <= present;
      if (present) begin
        tx_data_ff <= cur;
      end
    end else if (tx_ready) begin
      tx_valid_ff <= 1'b0;
    end
  end

  assign busy     = busy_ff;
  assign tx_valid = tx_valid_ff;
  assign tx_data  = tx_data_ff;

endmodule

// ### cgt_gate_ctl.sv
// Channel gate command interpreter with APB register access.
// Assumes a UART on pclk delivers received bytes and drains replies;
// the pins rts_pin and dflt_n_pin are asynchronous.
`timescale 1ns/10ps

// Operation
// - Any extended prompt closes the gate silently
// - Prompt plus own address alone opens gate
// - Long implied open echoes address, command, checksum
// - Appended module command opens and passes through
// - Short explicit close answers prompt only
// - Long explicit close answers echo and checksum
// - Explicit open answers like explicit close
// - Accept command checksums, answer with checksum in long form
// - Normal prompt starts address and command check
// - Transparent mode forwards all data unchanged
// - Ten-bit characters, seven-plus-parity or eight
// - Transparent mode provides RTS/CTS handshake
// - Transparent enable only via setup, any mode
// - Setup byte four: bit4 filter, bit5 transparent
// - Fallback pin: 300 baud, no parity, any address
// - Leaving transparent needs fallback mode first
// - Gate closed after reset
// - Long prompt echoes, short prompt answers minimally
// - Act only on own address: two characters extended, one normal
module cgt_gate_ctl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Received characters from modem side
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  // Replies toward modem side
  input  wire logic        tx_ready,
  output      logic        tx_valid,
  output      logic [7:0]  tx_data,
  // Characters onto the RS-485 string
  output      logic        bus_valid,
  output      logic [7:0]  bus_data,
  // Pins and line format
  input  wire logic        rts_pin,
  output      logic        cts_pin,
  input  wire logic        dflt_n_pin,
  output      logic        baud_300,
  output      logic        char_fmt7
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cgt_pkg::cgt_state_e state_ff, nxt_state;
  logic [1:0]  ctrl_ff;
  logic [23:0] addr_ff;
  logic [31:0] setup_ff, arg_ff, rd_mux;
  logic [3:0]  argn_ff;
  logic [7:0]  a0_ff, a1_ff, c0_ff, c1_ff, ch, bus_data_ff;
  logic        gate_ff, we_arm_ff, long_ff, ext_cmd_ff, bus_valid_ff;
  logic [1:0]  rts_sync_ff, dflt_sync_ff;
  logic        cts_pin_ff, baud_300_ff, char_fmt7_ff;
  logic        pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic        fallback, transp, pass_all, open_path, ext_prompt, norm_prompt;
  logic        fwd, do_close, do_open, imp_open, do_exec, match, resp_busy;
  logic        is_oc, is_cc, is_we, is_su, is_rs, su_ok, resp_go, apb_wr;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rts_sync_ff  <= 2'b00;
      dflt_sync_ff <= 2'b11;
    end else begin
      rts_sync_ff  <= {rts_sync_ff[0], rts_pin};
      dflt_sync_ff <= {dflt_sync_ff[0], dflt_n_pin};
    end
  end

  assign fallback = !dflt_sync_ff[1];
  assign transp   = setup_ff[cgt_pkg::SU_TRANSP];
  // Fallback suspends pass-through so the setup stays reachable
  assign pass_all = transp && !fallback;

  // ----------------------------------------------------------------
  // Character classification
  // ----------------------------------------------------------------
  always_comb begin
    ch = rx_data;
    if (char_fmt7_ff) begin
      ch = {1'b0, rx_data[6:0]};
    end
  end

  assign ext_prompt  = ctrl_ff[cgt_pkg::CTRL_EXT] &&
                       (ch == cgt_pkg::CH_LBRACE || ch == cgt_pkg::CH_RBRACE);
  assign norm_prompt = ch == cgt_pkg::CH_DOLLAR || ch == cgt_pkg::CH_HASH;
  assign open_path   = !ctrl_ff[cgt_pkg::CTRL_EXT] || gate_ff;
  // Second address character sits above the first in the address register
  assign match       = fallback || (ext_cmd_ff ? ({ch, a0_ff} == addr_ff[23:8])
                                               : (ch == addr_ff[7:0]));
  assign is_oc = ext_cmd_ff && c0_ff == cgt_pkg::CH_O && c1_ff == cgt_pkg::CH_C;
  assign is_cc = ext_cmd_ff && c0_ff == cgt_pkg::CH_C && c1_ff == cgt_pkg::CH_C;
  assign is_we = c0_ff == cgt_pkg::CH_W && c1_ff == cgt_pkg::CH_E;
  assign is_su = c0_ff == cgt_pkg::CH_S && c1_ff == cgt_pkg::CH_U;
  assign is_rs = c0_ff == cgt_pkg::CH_R && c1_ff == cgt_pkg::CH_S;
  assign su_ok = we_arm_ff && argn_ff == cgt_pkg::SU_DIGITS &&
                 (arg_ff[cgt_pkg::SU_TRANSP] || !transp || fallback);

  // ----------------------------------------------------------------
  // Parser
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    fwd       = 1'b0;
    do_close  = 1'b0;
    do_open   = 1'b0;
    imp_open  = 1'b0;
    do_exec   = 1'b0;
    if (rx_valid && pass_all) begin
      fwd = 1'b1;
    end else if (rx_valid && ext_prompt) begin
      do_close  = 1'b1;
      nxt_state = cgt_pkg::ST_ADR1;
    end else if (rx_valid) begin
      fwd = !ext_cmd_ff && open_path;
      case (state_ff)
        cgt_pkg::ST_IDLE: begin
          fwd = open_path;
          if (norm_prompt) begin
            nxt_state = cgt_pkg::ST_ADR2;
          end
        end
        cgt_pkg::ST_ADR1: nxt_state = cgt_pkg::ST_ADR2;
        cgt_pkg::ST_ADR2: nxt_state = match ? cgt_pkg::ST_CMD1 : cgt_pkg::ST_SKIP;
        cgt_pkg::ST_CMD1: begin
          nxt_state = cgt_pkg::ST_CMD2;
          if (ext_cmd_ff && ch == cgt_pkg::CH_CR) begin
            imp_open  = 1'b1;
            nxt_state = cgt_pkg::ST_IDLE;
          end else if (ext_cmd_ff && norm_prompt) begin
            do_open   = 1'b1;
            fwd       = 1'b1;
            nxt_state = cgt_pkg::ST_ADR2;
          end
        end
        cgt_pkg::ST_CMD2: nxt_state = cgt_pkg::ST_TAIL;
        cgt_pkg::ST_TAIL: begin
          if (ch == cgt_pkg::CH_CR) begin
            do_exec   = 1'b1;
            nxt_state = cgt_pkg::ST_IDLE;
          end
        end
        cgt_pkg::ST_SKIP: begin
          if (ch == cgt_pkg::CH_CR) begin
            nxt_state = cgt_pkg::ST_IDLE;
          end
        end
        default: nxt_state = cgt_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= cgt_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Prompt form, address and command letters of the current line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {long_ff, ext_cmd_ff} <= 2'b00;
      {a0_ff, a1_ff, c0_ff, c1_ff} <= 32'h0000_0000;
    end else if (rx_valid && !pass_all) begin
      if (ext_prompt) begin
        long_ff    <= ch == cgt_pkg::CH_RBRACE;
        ext_cmd_ff <= 1'b1;
      end else if (norm_prompt && (state_ff == cgt_pkg::ST_IDLE || do_open)) begin
        long_ff    <= ch == cgt_pkg::CH_HASH;
        ext_cmd_ff <= 1'b0;
      end else if (state_ff == cgt_pkg::ST_ADR1) begin
        a0_ff <= ch;
      end else if (state_ff == cgt_pkg::ST_ADR2) begin
        if (ext_cmd_ff) begin
          a1_ff <= ch;
        end else begin
          a0_ff <= ch;
        end
      end else if (state_ff == cgt_pkg::ST_CMD1) begin
        c0_ff <= ch;
      end else if (state_ff == cgt_pkg::ST_CMD2) begin
        c1_ff <= ch;
      end
    end
  end

  // Setup digits; trailing checksum digits beyond eight are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arg_ff  <= 32'h0000_0000;
      argn_ff <= 4'h0;
    end else if (rx_valid && state_ff == cgt_pkg::ST_CMD2) begin
      argn_ff <= 4'h0;
    end else if (rx_valid && state_ff == cgt_pkg::ST_TAIL && cgt_pkg::is_hex(ch) &&
                 argn_ff < cgt_pkg::SU_DIGITS && !pass_all) begin
      arg_ff  <= {arg_ff[27:0], cgt_pkg::hex2nib(ch)};
      argn_ff <= 4'(argn_ff + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Gate, write enable and setup
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_ff <= 1'b0;
    end else if (do_close || (do_exec && is_cc)) begin
      gate_ff <= 1'b0;
    end else if (do_open || imp_open || (do_exec && is_oc)) begin
      gate_ff <= 1'b1;
    end
  end

  // Any other executed command disarms the setup write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_arm_ff <= 1'b0;
    end else if (do_exec || imp_open || do_open) begin
      we_arm_ff <= do_exec && is_we;
    end
  end

  // Serial setup works in normal and extended addressing alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_ff <= cgt_pkg::SETUP_RST;
    end else if (do_exec && is_su && su_ok) begin
      setup_ff <= arg_ff;
    end
  end

  // ----------------------------------------------------------------
  // Outputs toward bus and pins
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_valid_ff <= 1'b0;
      bus_data_ff  <= 8'h00;
    end else begin
      bus_valid_ff <= fwd;
      if (fwd) begin
        bus_data_ff <= rx_data;
      end
    end
  end

  // Handshake only meaningful while passing raw traffic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_pin_ff   <= 1'b0;
      baud_300_ff  <= 1'b0;
      char_fmt7_ff <= 1'b0;
    end else begin
      cts_pin_ff   <= pass_all && rts_sync_ff[1];
      baud_300_ff  <= fallback;
      char_fmt7_ff <= ctrl_ff[cgt_pkg::CTRL_FMT7] && !fallback;
    end
  end

  // ----------------------------------------------------------------
  // Replies
  // ----------------------------------------------------------------
  assign resp_go = imp_open || (do_exec && (is_oc || is_cc || is_we || is_rs ||
                                            (is_su && su_ok)));

  cgt_resp_tx u_resp (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (resp_go),
    .long_form (long_ff),
    .two_addr  (ext_cmd_ff),
    .a0        (a0_ff),
    .a1        (a1_ff),
    .c0        (imp_open ? cgt_pkg::CH_O : c0_ff),
    .c1        (imp_open ? cgt_pkg::CH_C : c1_ff),
    .has_data  (do_exec && is_rs),
    .data      (setup_ff),
    .busy      (resp_busy),
    .tx_ready  (tx_ready),
    .tx_valid  (tx_valid),
    .tx_data   (tx_data)
  );

  // ----------------------------------------------------------------
  // APB slave, no wait states
  // ----------------------------------------------------------------
  always_comb begin
    case (paddr)
      cgt_pkg::REG_CTRL:   rd_mux = {30'h0, ctrl_ff};
      cgt_pkg::REG_ADDR:   rd_mux = {8'h00, addr_ff};
      cgt_pkg::REG_SETUP:  rd_mux = setup_ff;
      cgt_pkg::REG_STATUS: rd_mux = {27'h0, we_arm_ff, fallback,
                                     setup_ff[cgt_pkg::SU_FILTER], transp, gate_ff};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  assign apb_wr = psel && penable && pready_ff && pwrite && !pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && paddr > cgt_pkg::REG_STATUS;
      if (psel && !penable && !pwrite) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= cgt_pkg::CTRL_RST;
      addr_ff <= cgt_pkg::ADDR_RST;
    end else if (apb_wr && paddr == cgt_pkg::REG_CTRL) begin
      ctrl_ff <= pwdata[1:0];
    end else if (apb_wr && paddr == cgt_pkg::REG_ADDR) begin
      addr_ff <= pwdata[23:0];
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign bus_valid = bus_valid_ff;
  assign bus_data  = bus_data_ff;
  assign cts_pin   = cts_pin_ff;
  assign baud_300  = baud_300_ff;
  assign char_fmt7 = char_fmt7_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  imp_close_a: assert property (rx_valid && !pass_all && ext_prompt |=> !gate_ff)
    else $error("gate open after extended prompt");
  imp_open_a: assert property (imp_open |=> gate_ff)
    else $error("gate closed after address-only open");
  imp_resp_a: assert property (imp_open && !resp_busy && !tx_valid |=> resp_busy
                               ##1 tx_valid && tx_data == cgt_pkg::CH_STAR)
    else $error("no reply prompt after implied open");
  append_pass_a: assert property (do_open |=> gate_ff && bus_valid_ff
                                  && bus_data_ff == $past(rx_data))
    else $error("appended module command not passed");
  close_exec_a: assert property (do_exec && is_cc |=> !gate_ff ##1 !gate_ff || !do_open)
    else $error("gate not closed by explicit close");
  transp_pass_a: assert property (rx_valid && pass_all |=> bus_valid_ff
                                  && bus_data_ff == $past(rx_data))
    else $error("transparent byte not forwarded");
  cts_gate_a: assert property (!pass_all |=> !cts_pin_ff)
    else $error("clear to send outside transparent mode");
  su_guard_a: assert property (do_exec && is_su && !we_arm_ff
                               |=> setup_ff == $past(setup_ff))
    else $error("setup changed without write enable");
  transp_keep_a: assert property (transp && !fallback && !(do_exec && is_su)
                                  |=> transp)
    else $error("transparent mode left outside fallback");
  fallback_a: assert property (fallback |=> baud_300_ff && !char_fmt7_ff)
    else $error("fallback format not applied");

  open_cov_c: cover property (imp_open ##[1:40] tx_valid && tx_ready);
  pass_cov_c: cover property (do_open ##1 bus_valid_ff [*3]);
  su_cov_c: cover property (do_exec && is_su && su_ok);

endmodule

// ### cgt_sink_model.sv
// Modem-side sink that takes reply bytes, either at once or stalling.
// Assumes replies arrive as a valid/ready byte stream on pclk.
`timescale 1ns/10ps
module cgt_sink_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Reply stream
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output      logic       tx_ready,
  // Taken byte
  output      logic       got,
  output      logic [7:0] got_data
);
  logic tog_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tog_ff <= 1'b0;
    else tog_ff <= ~tog_ff;
  end

  // Stall every other cycle so an offered byte must wait
  assign tx_ready = presetn & (~slow | tog_ff);
  assign got      = tx_valid & tx_ready;
  assign got_data = tx_data;
endmodule

// ### tb.sv
// Testbench for the channel gate: APB and byte-line tasks with checks.
// Assumes cgt_gate_ctl and the reply sink model are compiled first.
`timescale 1ns/10ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_valid, tx_ready;
  logic tx_valid, bus_valid, rts_pin, cts_pin, dflt_n_pin, baud_300, char_fmt7, slow, got;
  logic [7:0] paddr, rx_data, tx_data, bus_data, got_data;
  logic [31:0] pwdata, prdata, r;
  logic [63:0] rsp = '0, bus_ff = '0;
  logic x, clr;
  int cnt = 0, cyc = 0, failures, tests_run;

  cgt_gate_ctl i_cgt_gate_ctl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .bus_valid(bus_valid), .bus_data(bus_data),
    .rts_pin(rts_pin), .cts_pin(cts_pin), .dflt_n_pin(dflt_n_pin), .baud_300(baud_300),
    .char_fmt7(char_fmt7));
  cgt_sink_model i_cgt_sink_model (.pclk(pclk), .presetn(presetn), .slow(slow),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .got(got),
    .got_data(got_data));

  // ----------------------------------------------------------------
  // Clock, capture and timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Capture registers have this one driver; tasks ask for a clear via clr
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (clr) begin
      rsp    <= '0;
      bus_ff <= '0;
      cnt    <= 0;
    end else begin
      if (got) begin
        rsp <= {rsp[55:0], got_data};
        cnt <= cnt + 1;
      end
      if (bus_valid) bus_ff <= {bus_ff[55:0], bus_data};
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sends a line and CR, waits for n reply bytes (n < 0: reply not checked)
  task automatic line(input string s, input logic [63:0] e, input int n,
                      input logic [31:0] st, input logic [31:0] m);
    clr <= 1'b1;
    for (int i = 0; i <= s.len(); i++) begin
      @(posedge pclk);
      clr <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= (i == s.len()) ? cgt_pkg::CH_CR : s[i];
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    for (int k = 0; k < 200 && cnt != n; k++) @(posedge pclk);
    repeat (8) @(posedge pclk);
    if (n >= 0) chk(s, e, rsp);
    apb(cgt_pkg::REG_STATUS, 1'b0, '0);
    chk("status", {32'h0, st}, {32'h0, r & m});
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, rx_valid, rts_pin, slow, clr} = '0;
    {paddr, rx_data, pwdata} = '0;
    dflt_n_pin = 1'b1;
    fork
      begin
        while (cyc < 20000) @(posedge pclk);
        failures++;
        complete_run();
      end
    join_none
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(cgt_pkg::REG_STATUS, 1'b0, '0);
    chk("status", 64'h0, {32'h0, r});
    apb(cgt_pkg::REG_SETUP, 1'b0, '0);
    chk("setup", 64'h3107_0000, {32'h0, r});
    apb(8'h10, 1'b0, '0);
    chk("unmapped", 64'h1, {r, 31'h0, x});
    line("}01", "*01OC1D\r", 8, 32'h1, 32'h1);
    slow <= 1'b1;
    line("}01CC", "*01CC11\r", 8, 32'h0, 32'h1);
    slow <= 1'b0;
    line("{01OC", "*\r", 2, 32'h1, 32'h1);
    line("{01CC", "*\r", 2, 32'h0, 32'h1);
    line("}01OC65", "*01OC1D\r", 8, 32'h1, 32'h1);
    line("{01$1RD", 0, 0, 32'h1, 32'h1);
    chk("bus", "$1RD\r", bus_ff);
    line("{02", 0, 0, 32'h0, 32'h1);
    apb(cgt_pkg::REG_CTRL, 1'b1, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk("fmt7", 64'h1, {63'h0, char_fmt7});
    line("$1SU31070030", 0, -1, 32'h0, 32'h1E);
    line("$1RS", "1070000\r", 10, 32'h0, 32'h1E);
    line("$1WE", "*\r", 2, 32'h10, 32'h1E);
    line("$1SU31070030", "*\r", 2, 32'h06, 32'h1E);
    apb(cgt_pkg::REG_SETUP, 1'b0, '0);
    chk("setup", 64'h3107_0030, {32'h0, r});
    line("=0*", 0, -1, 32'h06, 32'h1E);
    chk("bus", "=0*\r", bus_ff);
    rts_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("cts", 64'h1, {63'h0, cts_pin});
    dflt_n_pin <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("fallback", 64'h2, {62'h0, baud_300, char_fmt7});
    line("$5WE", "*\r", 2, 32'h1E, 32'h1E);
    line("$5SU31070000", "*\r", 2, 32'h08, 32'h1E);
    chk("cts", 64'h0, {63'h0, cts_pin});
    complete_run();
  end
endmodule
